// *** logic/crsse_exec.sv ***
`timescale 1ns/1ns
// What this block does
// - Literal return pops PC, loads literal, flags kept.
// - Interrupt return pops PC, sets global enable.
// - Pending interrupt is serviced before resuming main.
// - Plain rotate left, bit 7 into bit 0.
// - Rotate left through carry, only carry changes.
// - Plain rotate right, bit 0 into bit 7.
// - Rotate right through carry, only carry changes.
// - Borrow subtract to working register, four flags.
// - Borrow subtract to memory, same four flags.
// - Carry clear when negative, set otherwise.
// - Memory subtract to working register or memory.
// - Literal subtract into working register, four flags.
// - Decrement memory, write back, skip on zero.
// - Decrement into working register, skip on zero.
// - Increment memory, write back, skip on zero.
// - Increment into working register, skip on zero.
// - Every conditional skip takes two cycles.
// - Skip when selected memory bit is set.
// - Byte set writes all ones, flags kept.
// - Bit set forces one bit, flags kept.

module crsse_exec
   import crsse_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic OP_VALID,
   input wire logic [4:0] OP_CODE,
   input wire logic [7:0] OP_LITERAL,
   input wire logic [2:0] OP_BIT,
   input wire logic [7:0] MEM_RDATA,
   input wire logic [12:0] STACK_TOP,
   input wire logic IRQ_PENDING,
   input wire logic GIE_CLEAR,
   input wire logic WORK_LOAD,
   input wire logic [7:0] WORK_DATA,
   input wire logic STATUS_LOAD,
   input wire logic [3:0] STATUS_DATA,
   output logic BUSY,
   output logic DONE,
   output logic [7:0] WORKING_REGISTER,
   output logic CARRY_FLAG,
   output logic ZERO_FLAG,
   output logic HALF_CARRY_FLAG,
   output logic SIGNED_WRAP_FLAG,
   output logic GLOBAL_IRQ_ENABLE,
   output logic MEM_WE,
   output logic [7:0] MEM_WDATA,
   output logic SKIP_NEXT,
   output logic PC_LOAD,
   output logic [12:0] PC_VALUE,
   output logic STACK_POP,
   output logic IRQ_SERVE
);

   // All state of the sequencer, registered as one word.
   typedef struct packed {
      logic busy; // Second cycle of a two-cycle operation is running.
      logic done; // Operation finished in this cycle.
      logic [7:0] work; // Working register.
      logic carry; // Carry flag.
      logic zero; // Zero flag.
      logic half; // Half carry flag.
      logic wrap; // Signed overflow flag.
      logic gie; // Global interrupt enable.
      logic mem_we; // Memory write strobe.
      logic [7:0] mem_wdata; // Data for the memory write.
      logic skip; // The following instruction is to be dropped.
      logic pc_load; // Program counter takes pc_value.
      logic [12:0] pc_value; // Address to continue from.
      logic stack_pop; // Stack gives up its top entry.
      logic irq_serve; // Pending interrupt is entered before the popped address.
   } crsse_state_t;

   // Reset image of the state.
   localparam crsse_state_t CRSSE_STATE_RST = '{
      busy: 1'b0,
      done: 1'b0,
      work: CRSSE_WORK_RST,
      carry: CRSSE_FLAG_RST,
      zero: CRSSE_FLAG_RST,
      half: CRSSE_FLAG_RST,
      wrap: CRSSE_FLAG_RST,
      gie: CRSSE_GIE_RST,
      mem_we: 1'b0,
      mem_wdata: CRSSE_ZERO,
      skip: 1'b0,
      pc_load: 1'b0,
      pc_value: CRSSE_PC_RST,
      stack_pop: 1'b0,
      irq_serve: 1'b0
   };

   // Current and next state.
   crsse_state_t st;
   crsse_state_t next_st;

   // Link to the subtract unit.
   crsse_sub_if sub ();

   // The subtractor is kept apart so its flag logic can be checked on its own.
   crsse_sub_unit u_sub (
      .sub(sub)
   );

   // Decoded operation, valid only while a request is taken.
   crsse_op_t op;
   // A request is taken when offered and the sequencer is free.
   logic take;
   // Rotations of the memory operand, with and without carry.
   logic [7:0] rot_left;
   logic [7:0] rot_right;
   logic [7:0] rot_left_cy;
   logic [7:0] rot_right_cy;
   // Memory operand plus or minus one.
   logic [7:0] dec_val;
   logic [7:0] inc_val;
   // Selected bit of the memory operand.
   logic sel_bit;
   // Mask with only the selected bit set.
   logic [7:0] bit_mask;

   assign take = OP_VALID & ~st.busy;
   assign op = crsse_op_t'(OP_CODE);

   // Operand shaping that several operations share.
   always_comb begin
      rot_left = {MEM_RDATA[6:0], MEM_RDATA[7]};
      rot_right = {MEM_RDATA[0], MEM_RDATA[7:1]};
      rot_left_cy = {MEM_RDATA[6:0], st.carry};
      rot_right_cy = {st.carry, MEM_RDATA[7:1]};
      dec_val = MEM_RDATA - CRSSE_ONE;
      inc_val = MEM_RDATA + CRSSE_ONE;
      sel_bit = MEM_RDATA[OP_BIT];
      bit_mask = CRSSE_ONE << OP_BIT;
   end

   // Feed the subtractor; the literal form uses the instruction's own operand.
   always_comb begin
      sub.minuend = st.work;
      sub.subtrahend = (op == OP_DIFFERENCE_LITERAL) ? OP_LITERAL : MEM_RDATA;
      // Borrow forms take the carry flag; its complement is the borrow.
      if ((op == OP_SUBTRACT_BORROW_TO_WORK) || (op == OP_SUBTRACT_BORROW_TO_MEM)) begin
         sub.carry_in = st.carry;
      end else begin
         sub.carry_in = 1'b1;
      end
   end

   // Next-state logic of the whole sequencer.
   always_comb begin
      next_st = st;
      // Strobes last a single cycle unless set again below.
      next_st.done = 1'b0;
      next_st.mem_we = 1'b0;
      next_st.skip = 1'b0;
      next_st.pc_load = 1'b0;
      next_st.stack_pop = 1'b0;
      next_st.irq_serve = 1'b0;

      // Loads from the rest of the core come first so this block's own results win over them.
      if (WORK_LOAD) begin
         next_st.work = WORK_DATA;
      end
      if (STATUS_LOAD) begin
         next_st.carry = STATUS_DATA[CRSSE_ST_CARRY];
         next_st.half = STATUS_DATA[CRSSE_ST_HALF];
         next_st.zero = STATUS_DATA[CRSSE_ST_ZERO];
         next_st.wrap = STATUS_DATA[CRSSE_ST_WRAP];
      end
      // Interrupt entry clears the enable; a set in the same cycle overrides it below.
      if (GIE_CLEAR) begin
         next_st.gie = 1'b0;
      end

      if (st.busy) begin
         // Dummy cycle while the next instruction is fetched.
         next_st.busy = 1'b0;
         next_st.done = 1'b1;
      end else if (take) begin
         unique case (op)
            OP_RETURN_WITH_LITERAL: begin
               // Pop, continue there, and load the literal; flags stay.
               next_st.stack_pop = 1'b1;
               next_st.pc_load = 1'b1;
               next_st.pc_value = STACK_TOP;
               next_st.work = OP_LITERAL;
               next_st.busy = 1'b1;
            end
            OP_INTERRUPT_RETURN: begin
               // Pop and re-enable interrupts; arithmetic flags stay.
               next_st.stack_pop = 1'b1;
               next_st.pc_load = 1'b1;
               next_st.pc_value = STACK_TOP;
               next_st.gie = 1'b1;
               // A waiting request is entered before the main program resumes.
               next_st.irq_serve = IRQ_PENDING;
               next_st.busy = 1'b1;
            end

            // Rotations touch carry at most.
            OP_ROTATE_LEFT_MEM: begin
               next_st.mem_we = 1'b1;
               next_st.mem_wdata = rot_left;
               next_st.done = 1'b1;
            end
            OP_ROTATE_LEFT_TO_WORK: begin
               // Memory is left alone in the working-register form.
               next_st.work = rot_left;
               next_st.done = 1'b1;
            end
            OP_ROTATE_LEFT_THRU_CY: begin
               next_st.mem_we = 1'b1;
               next_st.mem_wdata = rot_left_cy;
               next_st.carry = MEM_RDATA[7];
               next_st.done = 1'b1;
            end
            OP_ROTATE_LEFT_THRU_CY_TO_WORK: begin
               next_st.work = rot_left_cy;
               next_st.carry = MEM_RDATA[7];
               next_st.done = 1'b1;
            end
            OP_ROTATE_RIGHT_MEM: begin
               next_st.mem_we = 1'b1;
               next_st.mem_wdata = rot_right;
               next_st.done = 1'b1;
            end
            OP_ROTATE_RIGHT_TO_WORK: begin
               next_st.work = rot_right;
               next_st.done = 1'b1;
            end
            OP_ROTATE_RIGHT_VIA_CY: begin
               next_st.mem_we = 1'b1;
               next_st.mem_wdata = rot_right_cy;
               next_st.carry = MEM_RDATA[0];
               next_st.done = 1'b1;
            end
            OP_ROTATE_RIGHT_VIA_CY_TO_WORK: begin
               next_st.work = rot_right_cy;
               next_st.carry = MEM_RDATA[0];
               next_st.done = 1'b1;
            end

            OP_SUBTRACT_BORROW_TO_WORK, OP_DIFFERENCE_TO_WORK, OP_DIFFERENCE_LITERAL: begin
               // Result into the working register with all four flags.
               next_st.work = sub.diff;
               next_st.carry = sub.carry_out;
               next_st.half = sub.half_borrow;
               next_st.zero = sub.zero;
               next_st.wrap = sub.wrap;
               next_st.done = 1'b1;
            end
            OP_SUBTRACT_BORROW_TO_MEM, OP_DIFFERENCE_TO_MEM: begin
               // Result into the addressed byte with all four flags.
               next_st.mem_we = 1'b1;
               next_st.mem_wdata = sub.diff;
               next_st.carry = sub.carry_out;
               next_st.half = sub.half_borrow;
               next_st.zero = sub.zero;
               next_st.wrap = sub.wrap;
               next_st.done = 1'b1;
            end

            // Skips need the dummy cycle.
            OP_DECREMENT_SKIP_ZERO: begin
               next_st.mem_we = 1'b1;
               next_st.mem_wdata = dec_val;
               next_st.skip = (dec_val == CRSSE_ZERO);
               next_st.busy = 1'b1;
            end
            OP_DECREMENT_TO_WORK_SKIP_ZERO: begin
               next_st.work = dec_val;
               next_st.skip = (dec_val == CRSSE_ZERO);
               next_st.busy = 1'b1;
            end
            OP_INCREMENT_SKIP_ZERO: begin
               next_st.mem_we = 1'b1;
               next_st.mem_wdata = inc_val;
               next_st.skip = (inc_val == CRSSE_ZERO);
               next_st.busy = 1'b1;
            end
            OP_INCREMENT_TO_WORK_SKIP_ZERO: begin
               next_st.work = inc_val;
               next_st.skip = (inc_val == CRSSE_ZERO);
               next_st.busy = 1'b1;
            end

            OP_BIT_TEST_SKIP_NONZERO: begin
               next_st.skip = sel_bit;
               next_st.busy = 1'b1;
            end

            OP_BYTE_SET: begin
               next_st.mem_we = 1'b1;
               next_st.mem_wdata = CRSSE_ALL_ONES;
               next_st.done = 1'b1;
            end
            OP_BIT_SET: begin
               // Only the selected bit changes; the rest are copied back.
               next_st.mem_we = 1'b1;
               next_st.mem_wdata = MEM_RDATA | bit_mask;
               next_st.done = 1'b1;
            end

            default: begin
               // Codes outside this set are not ours; the request finishes with no effect.
               next_st.done = 1'b1;
            end
         endcase
      end
   end

   // One register for the whole state; reset loads constants only.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         st <= CRSSE_STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   // Every output is a field of the registered state.
   assign BUSY = st.busy;
   assign DONE = st.done;
   assign WORKING_REGISTER = st.work;
   assign CARRY_FLAG = st.carry;
   assign ZERO_FLAG = st.zero;
   assign HALF_CARRY_FLAG = st.half;
   assign SIGNED_WRAP_FLAG = st.wrap;
   assign GLOBAL_IRQ_ENABLE = st.gie;
   assign MEM_WE = st.mem_we;
   assign MEM_WDATA = st.mem_wdata;
   assign SKIP_NEXT = st.skip;
   assign PC_LOAD = st.pc_load;
   assign PC_VALUE = st.pc_value;
   assign STACK_POP = st.stack_pop;
   assign IRQ_SERVE = st.irq_serve;

endmodule : crsse_exec

// *** logic/crsse_pkg.sv ***
package crsse_pkg;

   // Widths of the data path, the program counter, the operation code and the bit index.
   localparam int CRSSE_DW = 8;
   localparam int CRSSE_PCW = 13;
   localparam int CRSSE_OPW = 5;
   localparam int CRSSE_BITW = 3;

   // Values after reset.
   localparam logic [7:0] CRSSE_WORK_RST = 8'h00;
   localparam logic [12:0] CRSSE_PC_RST = 13'h0000;
   localparam logic CRSSE_FLAG_RST = 1'b0;
   localparam logic CRSSE_GIE_RST = 1'b0;

   // Fixed data values used by the operations.
   localparam logic [7:0] CRSSE_ALL_ONES = 8'hff;
   localparam logic [7:0] CRSSE_ONE = 8'h01;
   localparam logic [7:0] CRSSE_ZERO = 8'h00;

   // Bit positions inside the status word that outside logic may load.
   localparam int CRSSE_ST_CARRY = 0;
   localparam int CRSSE_ST_HALF = 1;
   localparam int CRSSE_ST_ZERO = 2;
   localparam int CRSSE_ST_WRAP = 3;

   // Operation codes presented on the command port.
   typedef enum logic [4:0] {
      OP_RETURN_WITH_LITERAL = 5'h00,
      OP_INTERRUPT_RETURN = 5'h01,
      OP_ROTATE_LEFT_MEM = 5'h02,
      OP_ROTATE_LEFT_TO_WORK = 5'h03,
      OP_ROTATE_LEFT_THRU_CY = 5'h04,
      OP_ROTATE_LEFT_THRU_CY_TO_WORK = 5'h05,
      OP_ROTATE_RIGHT_MEM = 5'h06,
      OP_ROTATE_RIGHT_TO_WORK = 5'h07,
      OP_ROTATE_RIGHT_VIA_CY = 5'h08,
      OP_ROTATE_RIGHT_VIA_CY_TO_WORK = 5'h09,
      OP_SUBTRACT_BORROW_TO_WORK = 5'h0a,
      OP_SUBTRACT_BORROW_TO_MEM = 5'h0b,
      OP_DIFFERENCE_TO_WORK = 5'h0c,
      OP_DIFFERENCE_TO_MEM = 5'h0d,
      OP_DIFFERENCE_LITERAL = 5'h0e,
      OP_DECREMENT_SKIP_ZERO = 5'h0f,
      OP_DECREMENT_TO_WORK_SKIP_ZERO = 5'h10,
      OP_INCREMENT_SKIP_ZERO = 5'h11,
      OP_INCREMENT_TO_WORK_SKIP_ZERO = 5'h12,
      OP_BIT_TEST_SKIP_NONZERO = 5'h13,
      OP_BYTE_SET = 5'h14,
      OP_BIT_SET = 5'h15
   } crsse_op_t;

endpackage : crsse_pkg

// *** logic/crsse_sub_if.sv ***
`timescale 1ns/1ns
// Operands and results of the subtractor, shared by the sequencer and the subtract unit.
interface crsse_sub_if;
   import crsse_pkg::*;
   logic [7:0] minuend; // Working register value.
   logic [7:0] subtrahend; // Memory byte or literal.
   logic carry_in; // One for plain subtraction, the carry flag for borrow forms.
   logic [7:0] diff; // Eight-bit result.
   logic carry_out; // One when no borrow left bit 7.
   logic half_borrow; // One when the low nibble borrowed.
   logic wrap; // Signed overflow.
   logic zero; // Result is all zero.
   modport user (output minuend, subtrahend, carry_in, input diff, carry_out, half_borrow, wrap, zero);
   modport unit (input minuend, subtrahend, carry_in, output diff, carry_out, half_borrow, wrap, zero);
endinterface : crsse_sub_if

// *** logic/crsse_sub_unit.sv ***
`timescale 1ns/1ns
// Eight-bit subtractor built as an adder of the inverted subtrahend.
module crsse_sub_unit
   import crsse_pkg::*;
(
   crsse_sub_if.unit sub
);

   // Low nibble sum with its carry in bit 4.
   logic [4:0] low_sum;
   // Full sum with its carry in bit 8.
   logic [8:0] full_sum;

   // The carry in acts as "not borrow", so a set carry means nothing is taken away.
   always_comb begin
      low_sum = {1'b0, sub.minuend[3:0]} + {1'b0, ~sub.subtrahend[3:0]} + {4'h0, sub.carry_in};
      full_sum = {1'b0, sub.minuend} + {1'b0, ~sub.subtrahend} + {8'h00, sub.carry_in};
   end

   // Carry set means the result is positive or zero.
   assign sub.carry_out = full_sum[8];
   // The half carry reports a borrow out of the low nibble.
   assign sub.half_borrow = ~low_sum[4];
   // Signed overflow: operands of unlike sign and the result takes the subtrahend's sign.
   assign sub.wrap = (sub.minuend[7] ^ sub.subtrahend[7]) & (full_sum[7] ^ sub.minuend[7]);
   assign sub.diff = full_sum[7:0];
   assign sub.zero = (full_sum[7:0] == CRSSE_ZERO);

endmodule : crsse_sub_unit

// *** sim/crsse_exec_props.sv ***
`timescale 1ns/1ns
// Watches the executor ports and checks the timing and results of the operations.
module crsse_exec_props
   import crsse_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic OP_VALID,
   input wire logic [4:0] OP_CODE,
   input wire logic [7:0] OP_LITERAL,
   input wire logic [2:0] OP_BIT,
   input wire logic [7:0] MEM_RDATA,
   input wire logic [12:0] STACK_TOP,
   input wire logic IRQ_PENDING,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic [7:0] WORKING_REGISTER,
   input wire logic CARRY_FLAG,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic MEM_WE,
   input wire logic [7:0] MEM_WDATA,
   input wire logic SKIP_NEXT,
   input wire logic PC_LOAD,
   input wire logic [12:0] PC_VALUE,
   input wire logic STACK_POP,
   input wire logic IRQ_SERVE
);
   logic take; // A request is accepted at this edge.
   logic two_op; // Returns and skips insert a dummy cycle.
   logic [7:0] rd_q; // Memory byte seen at the take edge.
   logic [2:0] bit_q; // Bit index seen at the take edge.
   logic cy_q; // Carry before the operation, needed because the result overwrites it.
   assign take = OP_VALID && !BUSY;
   assign two_op = OP_CODE inside {5'h00, 5'h01, [5'h0f:5'h13]};

   // Keeps the operands of the accepted request so results can be compared a cycle later.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rd_q <= 8'h00;
         bit_q <= 3'h0;
         cy_q <= 1'b0;
      end else begin
         rd_q <= MEM_RDATA;
         bit_q <= OP_BIT;
         cy_q <= CARRY_FLAG;
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   a_single_done: assert property (take && !two_op |=> DONE && !BUSY)
      else $error("single cycle operation did not finish next cycle");
   a_skip_dummy: assert property (take && two_op |=> (BUSY && !DONE) ##1 (DONE && !BUSY))
      else $error("two cycle operation timing wrong");
   a_busy_single: assert property (BUSY |=> !BUSY)
      else $error("busy stood longer than one cycle");
   a_byte_ones: assert property (take && OP_CODE == OP_BYTE_SET |=> MEM_WE && MEM_WDATA == 8'hff)
      else $error("byte set did not write all ones");
   a_bit_force: assert property (take && OP_CODE == OP_BIT_SET |=>
      MEM_WE && MEM_WDATA == (rd_q | (8'h01 << bit_q)))
      else $error("bit set wrote wrong byte");
   a_rotl_wrap: assert property (take && OP_CODE == OP_ROTATE_LEFT_MEM |=>
      MEM_WE && MEM_WDATA == {rd_q[6:0], rd_q[7]})
      else $error("rotate left wrote wrong byte");
   a_rotr_carry: assert property (take && OP_CODE == OP_ROTATE_RIGHT_VIA_CY |=>
      MEM_WE && MEM_WDATA == {cy_q, rd_q[7:1]} && CARRY_FLAG == rd_q[0])
      else $error("rotate right through carry wrong");
   a_iret_enable: assert property (take && OP_CODE == OP_INTERRUPT_RETURN |=>
      PC_LOAD && STACK_POP && GLOBAL_IRQ_ENABLE && PC_VALUE == $past(STACK_TOP))
      else $error("interrupt return did not pop and enable");
   a_pending_serve: assert property (take && OP_CODE == OP_INTERRUPT_RETURN |=>
      IRQ_SERVE == $past(IRQ_PENDING))
      else $error("pending interrupt not served on return");
   a_dec_skip: assert property (take && OP_CODE == OP_DECREMENT_SKIP_ZERO |=>
      MEM_WE && MEM_WDATA == rd_q - 8'h01 && SKIP_NEXT == (rd_q == 8'h01))
      else $error("decrement skip wrong");
   a_ret_literal: assert property (take && OP_CODE == OP_RETURN_WITH_LITERAL |=>
      PC_LOAD ##1 (DONE && WORKING_REGISTER == $past(OP_LITERAL, 2)))
      else $error("literal return wrong");

   c_skip_seen: cover property (SKIP_NEXT);
   c_irq_serve: cover property (IRQ_SERVE);
   c_refused: cover property (BUSY && OP_VALID);
endmodule : crsse_exec_props

bind crsse_exec crsse_exec_props chk_u (.MCLK(MCLK), .RST(RST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
   .OP_LITERAL(OP_LITERAL), .OP_BIT(OP_BIT), .MEM_RDATA(MEM_RDATA), .STACK_TOP(STACK_TOP),
   .IRQ_PENDING(IRQ_PENDING), .BUSY(BUSY), .DONE(DONE), .WORKING_REGISTER(WORKING_REGISTER),
   .CARRY_FLAG(CARRY_FLAG), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA),
   .SKIP_NEXT(SKIP_NEXT), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .STACK_POP(STACK_POP), .IRQ_SERVE(IRQ_SERVE));

// *** sim/crsse_exec_tb.sv ***
`timescale 1ns/1ns
// Self-checking bench for the return, rotate, subtract and skip executor.
module crsse_exec_tb;
   import crsse_pkg::*;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic OP_VALID = 1'b0;
   logic [4:0] OP_CODE = 5'h00;
   logic [7:0] OP_LITERAL = 8'h00;
   logic [2:0] OP_BIT = 3'h0;
   logic [7:0] MEM_RDATA = 8'h00;
   logic [12:0] STACK_TOP = 13'h0000;
   logic IRQ_PENDING = 1'b0;
   logic GIE_CLEAR = 1'b0;
   logic WORK_LOAD = 1'b0;
   logic [7:0] WORK_DATA = 8'h00;
   logic STATUS_LOAD = 1'b0;
   logic [3:0] STATUS_DATA = 4'h0;
   logic BUSY, DONE, CARRY_FLAG, ZERO_FLAG, HALF_CARRY_FLAG, SIGNED_WRAP_FLAG, GLOBAL_IRQ_ENABLE;
   logic MEM_WE, SKIP_NEXT, PC_LOAD, STACK_POP, IRQ_SERVE;
   logic [7:0] WORKING_REGISTER, MEM_WDATA;
   logic [12:0] PC_VALUE;
   int err_count = 0;
   int total_checks = 0;
   logic [38:0] exp_q[$]; // One note per operation, oldest first.
   logic [7:0] ref_w = 8'h00; // Reference working register.
   logic [3:0] ref_f = 4'h0; // Reference flags: wrap, zero, half, carry.
   logic ref_g = 1'b0; // Reference global enable.
   logic [15:0] rnd = 16'h91b5; // Random source, fixed start.
   // Strobes gathered since the last done pulse, since returns and skips raise them a cycle early.
   logic s_we = 1'b0, s_sk = 1'b0, s_pl = 1'b0, s_sp = 1'b0, s_sv = 1'b0;
   logic [7:0] s_wd = 8'h00;
   logic [12:0] s_pv = 13'h0000;

   always #25 MCLK = ~MCLK;

   crsse_exec dut_u (.MCLK(MCLK), .RST(RST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_LITERAL(OP_LITERAL),
      .OP_BIT(OP_BIT), .MEM_RDATA(MEM_RDATA), .STACK_TOP(STACK_TOP), .IRQ_PENDING(IRQ_PENDING),
      .GIE_CLEAR(GIE_CLEAR), .WORK_LOAD(WORK_LOAD), .WORK_DATA(WORK_DATA), .STATUS_LOAD(STATUS_LOAD),
      .STATUS_DATA(STATUS_DATA), .BUSY(BUSY), .DONE(DONE), .WORKING_REGISTER(WORKING_REGISTER),
      .CARRY_FLAG(CARRY_FLAG), .ZERO_FLAG(ZERO_FLAG), .HALF_CARRY_FLAG(HALF_CARRY_FLAG),
      .SIGNED_WRAP_FLAG(SIGNED_WRAP_FLAG), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .MEM_WE(MEM_WE),
      .MEM_WDATA(MEM_WDATA), .SKIP_NEXT(SKIP_NEXT), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
      .STACK_POP(STACK_POP), .IRQ_SERVE(IRQ_SERVE));

   // Sixteen-bit shift register step for operand values.
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr

   // Eight-bit subtract with flags {wrap, zero, half borrow, carry} above the difference.
   function automatic logic [11:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [8:0] t;
      logic [4:0] n;
      t = {1'b0, a} + {1'b0, ~b} + 9'(ci);
      n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
      return {(a[7] ^ b[7]) & (t[7] ^ a[7]), t[7:0] == 8'h00, ~n[4], t[8], t[7:0]};
   endfunction : sub8

   task automatic check(input logic [38:0] seen, input logic [38:0] want);
      total_checks++;
      if (seen !== want) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic tally_and_finish;
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // Loads register and flags from outside, optionally clearing the global enable.
   task automatic load(input logic [7:0] w, input logic [3:0] f, input logic clr);
      OP_VALID <= 1'b0;
      WORK_LOAD <= 1'b1;
      WORK_DATA <= w;
      STATUS_LOAD <= 1'b1;
      STATUS_DATA <= f;
      GIE_CLEAR <= clr;
      ref_w = w;
      ref_f = f;
      if (clr) ref_g = 1'b0;
      @(posedge MCLK);
   endtask : load

   // Offers one operation and notes its expected result. Two-cycle ones stay offered through
   // the busy cycle, so a design that takes a request while busy shows an extra done pulse.
   task automatic op(input logic [4:0] code, input logic [7:0] lit, input logic [7:0] m, input logic [2:0] b,
      input logic [12:0] stk, input logic irq);
      logic [11:0] s;
      logic [7:0] r;
      logic we, sk, pl, sv;
      OP_VALID <= 1'b1;
      OP_CODE <= code;
      OP_LITERAL <= lit;
      OP_BIT <= b;
      MEM_RDATA <= m;
      STACK_TOP <= stk;
      IRQ_PENDING <= irq;
      WORK_LOAD <= 1'b0;
      STATUS_LOAD <= 1'b0;
      GIE_CLEAR <= 1'b0;
      sk = 1'b0;
      pl = code < 5'h02;
      sv = 1'b0;
      r = 8'h00;
      s = 12'h000;
      case (code)
         OP_RETURN_WITH_LITERAL: ref_w = lit;
         OP_INTERRUPT_RETURN: {ref_g, sv} = {1'b1, irq};
         OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_WORK: r = {m[6:0], m[7]};
         OP_ROTATE_LEFT_THRU_CY, OP_ROTATE_LEFT_THRU_CY_TO_WORK: {ref_f[0], r} = {m, ref_f[0]};
         OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_TO_WORK: r = {m[0], m[7:1]};
         OP_ROTATE_RIGHT_VIA_CY, OP_ROTATE_RIGHT_VIA_CY_TO_WORK: {r, ref_f[0]} = {ref_f[0], m};
         OP_SUBTRACT_BORROW_TO_WORK, OP_SUBTRACT_BORROW_TO_MEM: s = sub8(ref_w, m, ref_f[0]);
         OP_DIFFERENCE_TO_WORK, OP_DIFFERENCE_TO_MEM: s = sub8(ref_w, m, 1'b1);
         OP_DIFFERENCE_LITERAL: s = sub8(ref_w, lit, 1'b1);
         OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_TO_WORK_SKIP_ZERO: r = m - 8'h01;
         OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_TO_WORK_SKIP_ZERO: r = m + 8'h01;
         OP_BIT_TEST_SKIP_NONZERO: sk = m[b];
         OP_BYTE_SET: r = 8'hff;
         OP_BIT_SET: r = m | (8'h01 << b);
         default: ; // Unlisted codes change nothing.
      endcase
      if (code inside {[5'h0a:5'h0e]}) begin
         r = s[7:0];
         ref_f = s[11:8];
      end
      if (code inside {[5'h0f:5'h12]}) sk = (r == 8'h00);
      we = code inside {5'h02, 5'h04, 5'h06, 5'h08, 5'h0b, 5'h0d, 5'h0f, 5'h11, 5'h14, 5'h15};
      if (code inside {5'h03, 5'h05, 5'h07, 5'h09, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h12}) ref_w = r;
      exp_q.push_back({ref_w, ref_f, ref_g, we, we ? r : 8'h00, sk, pl, pl ? stk : 13'h0000, pl, sv});
      repeat ((code inside {5'h00, 5'h01, [5'h0f:5'h13]}) ? 2 : 1) @(posedge MCLK);
   endtask : op

   // Gathers strobes and compares the whole outcome at every done pulse.
   always @(negedge MCLK) begin
      if (!RST) begin
         s_we = s_we | MEM_WE;
         if (MEM_WE === 1'b1) s_wd = MEM_WDATA;
         s_sk = s_sk | SKIP_NEXT;
         s_pl = s_pl | PC_LOAD;
         if (PC_LOAD === 1'b1) s_pv = PC_VALUE;
         s_sp = s_sp | STACK_POP;
         s_sv = s_sv | IRQ_SERVE;
         if (DONE !== 1'b0) begin
            // A done pulse with nothing outstanding is always wrong.
            if (exp_q.size() == 0) begin
               check(39'h0, 39'h1);
            end else begin
               check({WORKING_REGISTER, SIGNED_WRAP_FLAG, ZERO_FLAG, HALF_CARRY_FLAG, CARRY_FLAG, GLOBAL_IRQ_ENABLE,
                  s_we, s_wd, s_sk, s_pl, s_pv, s_sp, s_sv}, exp_q.pop_front());
            end
            {s_we, s_sk, s_pl, s_sp, s_sv, s_wd, s_pv} = '0;
         end
      end
   end

   // Cuts a hung run short well beyond the few hundred cycles the tests need.
   initial begin
      repeat (3000) @(posedge MCLK);
      err_count++;
      tally_and_finish();
   end

   // Main sequence: reset, boundary cases, then codes 0 to 23 with random operands.
   initial begin
      repeat (5) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      #1 check(39'({BUSY, DONE, WORKING_REGISTER, CARRY_FLAG, GLOBAL_IRQ_ENABLE, MEM_WE, PC_VALUE}), 39'h0);
      @(posedge MCLK);
      load(8'h80, 4'h1, 1'b0);
      op(OP_DIFFERENCE_LITERAL, 8'h01, 8'h00, 3'h0, 13'h0000, 1'b0);
      op(OP_DIFFERENCE_TO_WORK, 8'h00, 8'h7f, 3'h0, 13'h0000, 1'b0);
      op(OP_DIFFERENCE_TO_MEM, 8'h00, 8'h01, 3'h0, 13'h0000, 1'b0);
      op(OP_DECREMENT_SKIP_ZERO, 8'h00, 8'h01, 3'h0, 13'h0000, 1'b0);
      op(OP_INCREMENT_TO_WORK_SKIP_ZERO, 8'h00, 8'hff, 3'h0, 13'h0000, 1'b0);
      op(OP_BIT_TEST_SKIP_NONZERO, 8'h00, 8'h80, 3'h7, 13'h0000, 1'b0);
      op(OP_INTERRUPT_RETURN, 8'h00, 8'h00, 3'h0, 13'h1fff, 1'b1);
      op(OP_RETURN_WITH_LITERAL, 8'h5a, 8'h00, 3'h0, 13'h0abc, 1'b0);
      op(5'h1f, 8'h00, 8'h00, 3'h0, 13'h0000, 1'b0);
      repeat (12) begin
         rnd = lfsr(rnd);
         load(rnd[7:0], rnd[11:8], rnd[12]);
         for (int c = 0; c < 24; c++) begin
            rnd = lfsr(rnd);
            op(5'(c), rnd[7:0], rnd[15:8], rnd[10:8], {rnd[4:0], rnd[15:8]}, rnd[5]);
         end
      end
      OP_VALID <= 1'b0;
      repeat (3) @(posedge MCLK);
      check(39'(exp_q.size()), 39'h0);
      tally_and_finish();
   end
endmodule : crsse_exec_tb
